//--- interval_counter_core.sv
`timescale 1ns/1ps
module interval_counter_core
    import interval_timer_pkg::*;
#(
    parameter int WIDTH = COUNT_W
) (
    input  logic             aclk,
    input  logic             aresetn,
    input  logic             hold,
    input  logic             tick,
    input  logic [WIDTH-1:0] compare,
    output logic [WIDTH-1:0] count,
    output logic             hit
);

    logic [WIDTH-1:0] count_reg;
    logic             hit_reg;

    // Counter: held at zero, advances per tick, clears on compare
    always_ff @(posedge aclk) begin
        if (!aresetn || hold) begin
            count_reg <= '0;
        end else if (tick) begin
            if (count_reg == compare) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // One-cycle pulse when the period completes
    always_ff @(posedge aclk) begin
        if (!aresetn || hold) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= tick && (count_reg == compare);
        end
    end

    assign count = count_reg;
    assign hit   = hit_reg;

endmodule : interval_counter_core

//--- interval_timer_asserts.sv
`timescale 1ns/1ps
module interval_timer_asserts
    import interval_timer_pkg::*;
(
    input logic        aclk,
    input logic        aresetn,
    input logic        count_clk_in,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        irq
);
    logic       pin_q;
    logic [7:0] since_ev;
    logic [7:0] since_w;
    logic       w_hit;
    logic       ev_hit;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Event strobes: write data taken, count pin rising
    assign w_hit  = s_axi_wvalid && s_axi_wready;
    assign ev_hit = w_hit || (count_clk_in && !pin_q);

    // Saturating cycle counts since the last event
    always_ff @(posedge aclk) begin
        pin_q <= count_clk_in;
        if (!aresetn) begin
            since_ev <= 8'hff;
            since_w  <= 8'hff;
        end else begin
            if (ev_hit)
                since_ev <= 8'h00;
            else if (since_ev != 8'hff)
                since_ev <= since_ev + 8'h01;
            if (w_hit)
                since_w <= 8'h00;
            else if (since_w != 8'hff)
                since_w <= since_w + 8'h01;
        end
    end

    AST_IRQ_RISE: assert property ($rose(irq) |-> since_ev < 8'd12)
        else $error("irq rose without a count edge or write");
    AST_IRQ_FALL: assert property ($fell(irq) |-> since_w < 8'd8)
        else $error("irq fell without a register write");
    AST_RST_QUIET: assert property (disable iff (1'b0)
        !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read returned nonzero data");

    // Main scenarios
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : interval_timer_asserts

bind periodic_interval_timer_12bit interval_timer_asserts u_chk (
    .aclk, .aresetn, .count_clk_in, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq
);

//--- interval_timer_pkg.sv
package interval_timer_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [5:0]  RESET_CTRL_OFF   = 6'h00;
    localparam logic [5:0]  CLOCK_EN_OFF     = 6'h04;
    localparam logic [5:0]  TIMER_CTRL_OFF   = 6'h08;
    localparam logic [5:0]  IRQ_FLAGS_OFF    = 6'h0c;
    localparam logic [5:0]  IRQ_MASK_OFF     = 6'h10;
    localparam logic [5:0]  COUNT_STAT_OFF   = 6'h14;

    // Field positions
    localparam int          RESET_HOLD_BIT   = 7;
    localparam int          CLOCK_GATE_BIT   = 7;
    localparam int          RUN_BIT          = 15;
    localparam int          COMPARE_MSB      = 11;
    localparam int          IRQ_BIT          = 1;

    // Counter width
    localparam int          COUNT_W          = 12;

    // Reset values
    localparam logic [7:0]  RESET_CTRL_RST   = 8'h00;
    localparam logic [7:0]  CLOCK_EN_RST     = 8'h00;
    localparam logic [15:0] TIMER_CTRL_RST   = 16'h031f;
    localparam logic [7:0]  IRQ_FLAGS_RST    = 8'h00;
    localparam logic [7:0]  IRQ_MASK_RST     = 8'h02;

    // Writable bits of each register
    localparam logic [7:0]  RESET_CTRL_MASK  = 8'h80;
    localparam logic [7:0]  CLOCK_EN_MASK    = 8'h80;
    localparam logic [15:0] TIMER_CTRL_MASK  = 16'h8fff;
    localparam logic [7:0]  IRQ_BITS_MASK    = 8'h02;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage : interval_timer_pkg

//--- periodic_interval_timer_12bit.sv
`timescale 1ns/1ps
// Contract
// - Reset hold bit set keeps timer reset
// - Clock gate bit supplies or stops count clock
// - Run bit starts or stops counting
// - Period is count clocks times compare plus one
// - Request flag set; mask one blocks servicing
module periodic_interval_timer_12bit
    import interval_timer_pkg::*;
(
    input  logic        aclk,
    input  logic        aresetn,
    input  logic        count_clk_in,
    input  logic [5:0]  s_axi_awaddr,
    input  logic [2:0]  s_axi_awprot,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [5:0]  s_axi_araddr,
    input  logic [2:0]  s_axi_arprot,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    output logic        irq
);

    // Byte-lane merge of write data into an old register value
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  wstrb
    );
        logic [15:0] res;
        res = old_val;
        if (wstrb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (wstrb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : merge16

    // Known register decode
    function automatic logic is_mapped(input logic [5:0] addr);
        return (addr == RESET_CTRL_OFF) || (addr == CLOCK_EN_OFF) ||
               (addr == TIMER_CTRL_OFF) || (addr == IRQ_FLAGS_OFF) ||
               (addr == IRQ_MASK_OFF)   || (addr == COUNT_STAT_OFF);
    endfunction : is_mapped

    // Bus handshake state
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic [5:0]  waddr_reg;
    logic        waddr_full_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wdata_full_reg;

    // Software registers
    logic [7:0]  reset_ctrl_reg;
    logic [7:0]  clock_en_reg;
    logic [15:0] timer_ctrl_reg;
    logic [7:0]  irq_flags_reg;
    logic [7:0]  irq_mask_reg;
    logic        irq_reg;

    // Count clock pin synchroniser and edge detect
    logic        cclk_meta_reg;
    logic        cclk_sync_reg;
    logic        cclk_prev_reg;

    // Derived controls
    logic        do_write;
    logic        wr_reset_ctrl;
    logic        wr_clock_en;
    logic        wr_timer_ctrl;
    logic        wr_irq_flags;
    logic        wr_irq_mask;
    logic        reset_hold;
    logic        clock_gate;
    logic        timer_run;
    logic        count_tick;
    logic        count_edge;
    logic        wr_legal;
    logic [COUNT_W-1:0] compare_value;
    logic [COUNT_W-1:0] count_value;
    logic        period_hit;
    logic [7:0]  irq_flags_next;

    // Write happens once address and data are both captured
    assign do_write = waddr_full_reg && wdata_full_reg && !bvalid_reg;

    // Write decode
    always_comb begin
        wr_reset_ctrl = 1'b0;
        wr_clock_en   = 1'b0;
        wr_timer_ctrl = 1'b0;
        wr_irq_flags  = 1'b0;
        wr_irq_mask   = 1'b0;
        if (!do_write) begin
            wr_reset_ctrl = 1'b0;
        end else if (waddr_reg == RESET_CTRL_OFF) begin
            wr_reset_ctrl = 1'b1;
        end else if (waddr_reg == CLOCK_EN_OFF) begin
            wr_clock_en = 1'b1;
        end else if (waddr_reg == TIMER_CTRL_OFF) begin
            wr_timer_ctrl = 1'b1;
        end else if (waddr_reg == IRQ_FLAGS_OFF) begin
            wr_irq_flags = 1'b1;
        end else if (waddr_reg == IRQ_MASK_OFF) begin
            wr_irq_mask = 1'b1;
        end
    end

    // Write address channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg    <= 1'b0;
            waddr_full_reg <= 1'b0;
            waddr_reg      <= 6'h00;
        end else if (s_axi_awvalid && awready_reg) begin
            awready_reg    <= 1'b0;
            waddr_full_reg <= 1'b1;
            waddr_reg      <= s_axi_awaddr;
        end else if (do_write) begin
            waddr_full_reg <= 1'b0;
        end else begin
            awready_reg <= !waddr_full_reg && !bvalid_reg;
        end
    end

    // Write data channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg     <= 1'b0;
            wdata_full_reg <= 1'b0;
            wdata_reg      <= 32'h0000_0000;
            wstrb_reg      <= 4'h0;
        end else if (s_axi_wvalid && wready_reg) begin
            wready_reg     <= 1'b0;
            wdata_full_reg <= 1'b1;
            wdata_reg      <= s_axi_wdata;
            wstrb_reg      <= s_axi_wstrb;
        end else if (do_write) begin
            wdata_full_reg <= 1'b0;
        end else begin
            wready_reg <= !wdata_full_reg && !bvalid_reg;
        end
    end

    // Writable offsets: mapped and not the read-only count status
    assign wr_legal = is_mapped(waddr_reg) && (waddr_reg != COUNT_STAT_OFF);

    // Write response, error on unmapped or read-only offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            if (wr_legal) begin
                bresp_reg <= RESP_OKAY;
            end else begin
                bresp_reg <= RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Reset control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_ctrl_reg <= RESET_CTRL_RST;
        end else if (wr_reset_ctrl && wstrb_reg[0]) begin
            reset_ctrl_reg <= wdata_reg[7:0] & RESET_CTRL_MASK;
        end
    end

    // Clock enable register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_en_reg <= CLOCK_EN_RST;
        end else if (wr_clock_en && wstrb_reg[0]) begin
            clock_en_reg <= wdata_reg[7:0] & CLOCK_EN_MASK;
        end
    end

    // Timer control register: run bit and compare value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_ctrl_reg <= TIMER_CTRL_RST;
        end else if (wr_timer_ctrl) begin
            timer_ctrl_reg <= merge16(timer_ctrl_reg, wdata_reg, wstrb_reg) & TIMER_CTRL_MASK;
        end
    end

    // Interrupt mask register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr_irq_mask && wstrb_reg[0]) begin
            irq_mask_reg <= wdata_reg[7:0] & IRQ_BITS_MASK;
        end
    end

    // Sticky request flag: write one clears, a new period end wins
    always_comb begin
        irq_flags_next = irq_flags_reg;
        if (wr_irq_flags && wstrb_reg[0]) begin
            irq_flags_next = irq_flags_reg & ~wdata_reg[7:0];
        end
        if (period_hit) begin
            irq_flags_next[IRQ_BIT] = 1'b1;
        end
    end

    // Flag register keeps only the timer request bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flags_reg <= IRQ_FLAGS_RST;
        end else begin
            irq_flags_reg <= irq_flags_next & IRQ_BITS_MASK;
        end
    end

    // Interrupt output, blocked while the mask bit is one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_flags_reg & ~irq_mask_reg & IRQ_BITS_MASK);
        end
    end

    // Read address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
        end else begin
            arready_reg <= !rvalid_reg;
        end
    end

    // Read data channel and mux
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            if (s_axi_araddr == RESET_CTRL_OFF) begin
                rdata_reg[7:0] <= reset_ctrl_reg;
            end else if (s_axi_araddr == CLOCK_EN_OFF) begin
                rdata_reg[7:0] <= clock_en_reg;
            end else if (s_axi_araddr == TIMER_CTRL_OFF) begin
                rdata_reg[15:0] <= timer_ctrl_reg;
            end else if (s_axi_araddr == IRQ_FLAGS_OFF) begin
                rdata_reg[7:0] <= irq_flags_reg;
            end else if (s_axi_araddr == IRQ_MASK_OFF) begin
                rdata_reg[7:0] <= irq_mask_reg;
            end else if (s_axi_araddr == COUNT_STAT_OFF) begin
                rdata_reg[COUNT_W-1:0] <= count_value;
            end else begin
                rresp_reg <= RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Count clock pin through two flops, then edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cclk_meta_reg <= 1'b0;
            cclk_sync_reg <= 1'b0;
            cclk_prev_reg <= 1'b0;
        end else begin
            cclk_meta_reg <= count_clk_in;
            cclk_sync_reg <= cclk_meta_reg;
            cclk_prev_reg <= cclk_sync_reg;
        end
    end

    // Control decode
    assign reset_hold    = reset_ctrl_reg[RESET_HOLD_BIT];
    assign clock_gate    = clock_en_reg[CLOCK_GATE_BIT];
    assign timer_run     = timer_ctrl_reg[RUN_BIT];
    assign compare_value = timer_ctrl_reg[COMPARE_MSB:0];

    // Synchronised rising edge of the count clock pin
    assign count_edge = cclk_sync_reg && !cclk_prev_reg;

    // Count clock rising edge, gated by supply enable and run
    assign count_tick = count_edge && clock_gate
                        && timer_run;

    // Counter core
    interval_counter_core #(
        .WIDTH   (COUNT_W)
    ) u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .hold    (reset_hold),
        .tick    (count_tick),
        .compare (compare_value),
        .count   (count_value),
        .hit     (period_hit)
    );

    // Outputs from flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign irq           = irq_reg;

endmodule : periodic_interval_timer_12bit

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR at %0t ns: got %h expected %h", $time, (a), (e)); end end
module tb_top;
    import interval_timer_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        count_clk_in = 1'b0;
    logic [5:0]  s_axi_awaddr = 6'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [5:0]  s_axi_araddr = 6'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        irq;
    int          num_errors = 0;
    int          checks_done = 0;
    logic [11:0] cmps [2] = '{12'h001, 12'h003};

    periodic_interval_timer_12bit dut (
        .aclk, .aresetn, .count_clk_in, .s_axi_awaddr, .s_axi_awprot(3'b000),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
    );

    // Clock at 40 MHz
    always #12.5 aclk = ~aclk;

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic hang;
        num_errors++;
        $display("ERROR at %0t ns: bus wait ran out", $time);
        print_verdict();
    endtask : hang

    // Write one word, response expected as er
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready)
                break;
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid)
                s_axi_bready <= 1'b1;
        end
        if (n == 40)
            hang();
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask : wr

    // Read one word and compare data and response
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready)
                break;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                s_axi_rready <= 1'b1;
        end
        if (n == 40)
            hang();
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
    endtask : rd

    // Pulses on the count clock pin
    task automatic tk(input int k);
        repeat (k) begin
            count_clk_in <= 1'b1;
            repeat (4) @(posedge aclk);
            count_clk_in <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask : tk

    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(RESET_CTRL_OFF, 32'h0000_0000, RESP_OKAY);
        rd(CLOCK_EN_OFF, 32'h0000_0000, RESP_OKAY);
        rd(TIMER_CTRL_OFF, 32'h0000_031f, RESP_OKAY);
        rd(IRQ_FLAGS_OFF, 32'h0000_0000, RESP_OKAY);
        rd(IRQ_MASK_OFF, 32'h0000_0002, RESP_OKAY);
        rd(6'h18, 32'h0000_0000, RESP_SLVERR);
        wr(6'h18, 32'hffff_ffff, RESP_SLVERR);
        wr(COUNT_STAT_OFF, 32'hffff_ffff, RESP_SLVERR);
        wr(TIMER_CTRL_OFF, 32'hffff_ffff, RESP_OKAY);
        rd(TIMER_CTRL_OFF, 32'h0000_8fff, RESP_OKAY);
        $display("test registers done");
        foreach (cmps[i]) begin
            wr(RESET_CTRL_OFF, 32'h0000_0080, RESP_OKAY);
            wr(CLOCK_EN_OFF, 32'h0000_0080, RESP_OKAY);
            wr(TIMER_CTRL_OFF, {16'h0000, 4'h8, cmps[i]}, RESP_OKAY);
            wr(IRQ_FLAGS_OFF, 32'h0000_0002, RESP_OKAY);
            wr(IRQ_MASK_OFF, 32'h0000_0000, RESP_OKAY);
            tk(2);
            rd(COUNT_STAT_OFF, 32'h0000_0000, RESP_OKAY);
            wr(RESET_CTRL_OFF, 32'h0000_0000, RESP_OKAY);
            tk(int'(cmps[i]));
            rd(COUNT_STAT_OFF, {20'h0_0000, cmps[i]}, RESP_OKAY);
            rd(IRQ_FLAGS_OFF, 32'h0000_0000, RESP_OKAY);
            `CHK(irq, 1'b0)
            tk(1);
            rd(COUNT_STAT_OFF, 32'h0000_0000, RESP_OKAY);
            rd(IRQ_FLAGS_OFF, 32'h0000_0002, RESP_OKAY);
            `CHK(irq, 1'b1)
        end
        $display("test period done");
        wr(IRQ_MASK_OFF, 32'h0000_0002, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(IRQ_FLAGS_OFF, 32'h0000_0002, RESP_OKAY);
        rd(IRQ_FLAGS_OFF, 32'h0000_0000, RESP_OKAY);
        $display("test mask done");
        tk(1);
        wr(TIMER_CTRL_OFF, 32'h0000_0003, RESP_OKAY);
        tk(2);
        rd(COUNT_STAT_OFF, 32'h0000_0001, RESP_OKAY);
        wr(TIMER_CTRL_OFF, 32'h0000_8003, RESP_OKAY);
        wr(CLOCK_EN_OFF, 32'h0000_0000, RESP_OKAY);
        tk(2);
        rd(COUNT_STAT_OFF, 32'h0000_0001, RESP_OKAY);
        wr(CLOCK_EN_OFF, 32'h0000_0080, RESP_OKAY);
        tk(1);
        rd(COUNT_STAT_OFF, 32'h0000_0002, RESP_OKAY);
        $display("test stop done");
        s_axi_wstrb <= 4'h1;
        wr(TIMER_CTRL_OFF, 32'hffff_0005, RESP_OKAY);
        rd(TIMER_CTRL_OFF, 32'h0000_8005, RESP_OKAY);
        s_axi_wstrb <= 4'h2;
        wr(CLOCK_EN_OFF, 32'h0000_0000, RESP_OKAY);
        rd(CLOCK_EN_OFF, 32'h0000_0080, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        $display("test strobe done");
        print_verdict();
    end
endmodule : tb_top
